/* File: design/spiefw_pkg.sv */
// Package: register offsets, field positions, reset values and carriers
// of the serial controller's event flag and wakeup logic.
// Assumes an APB slave with 32-bit data and byte addresses.
`default_nettype none

package spiefw_pkg;
    // Bus and field widths
    localparam int APB_AW = 8;
    localparam int CNT_W = 6;
    localparam int FLAG_W = 16;
    localparam int WAKE_W = 4;
    localparam int LEN_W = 5;

    // Register offsets (byte addresses)
    localparam logic [APB_AW-1:0] OFS_EVENT_FLAGS = 8'h20;
    localparam logic [APB_AW-1:0] OFS_EVENT_ENABLES = 8'h24;
    localparam logic [APB_AW-1:0] OFS_WAKE_FLAGS = 8'h28;
    localparam logic [APB_AW-1:0] OFS_WAKE_ENABLES = 8'h2C;
    localparam logic [APB_AW-1:0] OFS_CTRL = 8'h40;
    localparam logic [APB_AW-1:0] OFS_STATUS = 8'h44;

    // Event flag bit positions
    localparam int BIT_TX_LEVEL = 0;
    localparam int BIT_TX_EMPTY = 1;
    localparam int BIT_RX_LEVEL = 2;
    localparam int BIT_RX_FULL = 3;
    localparam int BIT_SSA = 4;
    localparam int BIT_SSD = 5;
    localparam int BIT_RSV_LO = 6;
    localparam int BIT_RSV_HI = 7;
    localparam int BIT_FAULT = 8;
    localparam int BIT_ABORT = 9;
    localparam int BIT_RSV_MID = 10;
    localparam int BIT_M_DONE = 11;
    localparam int BIT_TX_OVR = 12;
    localparam int BIT_TX_UND = 13;
    localparam int BIT_RX_OVR = 14;
    localparam int BIT_RX_UND = 15;

    // Implemented bits and reset values
    localparam logic [FLAG_W-1:0] EVENT_USED = 16'hFB3F;
    localparam logic [FLAG_W-1:0] EVENT_RST = 16'h0002;
    localparam logic [FLAG_W-1:0] ENABLE_RST = 16'h0000;
    localparam logic [WAKE_W-1:0] WAKE_USED = 4'hF;
    localparam logic [WAKE_W-1:0] WAKE_RST = 4'h0;

    // Control register fields
    localparam int CTRL_MASTER = 0;
    localparam int CTRL_MM_EN = 1;
    localparam int CTRL_LEN_LSB = 4;
    localparam logic [LEN_W-1:0] CHAR_BITS_RST = 5'h08;

    // FIFO occupancy and programmed thresholds
    typedef struct packed {
        logic [CNT_W-1:0] rx_count;
        logic [CNT_W-1:0] tx_count;
        logic [CNT_W-1:0] rx_thresh;
        logic [CNT_W-1:0] tx_thresh;
    } spiefw_fifo_t;

    // One-cycle event strobes from FIFOs and shifter
    typedef struct packed {
        logic rx_read_empty;
        logic rx_write_full;
        logic tx_read_empty;
        logic tx_write_full;
        logic master_done;
        logic collision;
    } spiefw_strb_t;
endpackage : spiefw_pkg

`default_nettype wire

/* File: design/spiefw_sync.sv */
// Two-stage synchroniser for a group of pin levels.
// Assumes the inputs are asynchronous to mclk.
`default_nettype none

module spiefw_sync #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] stage1;

    // First stage feeds only the second
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= '1;
            sync_out <= '1;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : spiefw_sync

`default_nettype wire

/* File: design/spiefw_flags.sv */
// Bank of sticky flags, set by hardware, cleared by writing one.
// Assumes set and clear arrive on mclk; set beats clear.
`default_nettype none

module spiefw_flags #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    output logic [W-1:0] q
);
    logic [W-1:0] next_q;

    // Set wins over a clear in the same cycle
    assign next_q = (q & ~clr) | set;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q <= RST_VAL;
        end else begin
            q <= next_q;
        end
    end
endmodule : spiefw_flags

`default_nettype wire

/* File: design/spiefw_top.sv */
// Event flags, interrupt enables and wakeup flags of a serial controller.
// Assumes FIFO counts and strobes come from logic on mclk, while the
// select lines and serial clock come from pins.
// Notes on behaviour
// - Slave select released mid character sets abort
// - Master, multi-master, foreign select sets fault
// - Bus collision also sets fault
// - Select line release sets released flag
// - Select line assertion sets asserted flag
// - Receive FIFO full sets full flag
// - Receive count above threshold sets flag
// - Transmit FIFO empty sets flag, reset one
// - Transmit count below threshold sets flag
// - Flags stay until software writes one
// - Enable bit per flag, reset zero
// - Enables for bits fifteen to eleven, nine, eight and five to zero
// - Wake flags bits three to zero, write-one-clear
// - Wake enables bits three to zero, reset zero
// - Read of empty receive FIFO sets underrun
// - Receive overrun flagged only as slave
// - Transmit underrun flagged only as slave
// - Master done flag when transactions finish
`default_nettype none

module spiefw_top #(
    parameter int NUM_SS = 4,
    parameter int FIFO_DEPTH = 32
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [spiefw_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sclk_in,
    input wire logic [NUM_SS-1:0] ss_n_in,
    input wire spiefw_pkg::spiefw_fifo_t fifo,
    input wire spiefw_pkg::spiefw_strb_t strb,
    output logic irq,
    output logic wake
);
    import spiefw_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Declarations
    logic [NUM_SS:0] pins_s;
    logic [NUM_SS-1:0] ss_s;
    logic [NUM_SS-1:0] ss_d;
    logic [NUM_SS-1:0] ss_asrt;
    logic [NUM_SS-1:0] ss_deas;
    logic sclk_s;
    logic sclk_d;
    logic sclk_rise;
    logic slave_sel;
    logic char_end;
    logic [LEN_W-1:0] bit_cnt;
    logic [LEN_W-1:0] next_bit_cnt;
    logic ctrl_master;
    logic ctrl_mm;
    logic [LEN_W-1:0] ctrl_len;
    logic [FLAG_W-1:0] event_q;
    logic [FLAG_W-1:0] event_en;
    logic [FLAG_W-1:0] ev_set;
    logic [FLAG_W-1:0] ev_clr;
    logic [WAKE_W-1:0] wake_q;
    logic [WAKE_W-1:0] wake_en;
    logic [WAKE_W-1:0] wk_clr;
    logic sel_ev;
    logic sel_en;
    logic sel_wk;
    logic sel_wen;
    logic sel_ctrl;
    logic sel_stat;
    logic addr_hit;
    logic acc_first;
    logic wr_fire;
    logic [FLAG_W-1:0] stat16;
    logic [31:0] rd_data;

    // Widen a 16-bit field to a bus word
    function automatic logic [31:0] pad16(input logic [15:0] v);
        pad16 = {16'h0000, v};
    endfunction : pad16

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection
    spiefw_sync #(
        .W(NUM_SS + 1)
    ) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .async_in({sclk_in, ss_n_in}),
        .sync_out(pins_s)
    );

    assign ss_s = pins_s[NUM_SS-1:0];
    assign sclk_s = pins_s[NUM_SS];

    // Previous synchronised levels
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ss_d <= '1;
            // Match the synchroniser's reset level so no false rise follows
            sclk_d <= 1'b1;
        end else begin
            ss_d <= ss_s;
            sclk_d <= sclk_s;
        end
    end

    // Select lines are active low
    assign ss_asrt = ss_d & ~ss_s;
    assign ss_deas = ~ss_d & ss_s;
    assign sclk_rise = sclk_s & ~sclk_d;
    assign slave_sel = ~ss_s[0];

    ////////////////////////////////////////////////////////////////////
    // Bit counter within a slave character
    assign char_end = (bit_cnt + 5'h01) >= ctrl_len;
    assign next_bit_cnt = !slave_sel ? '0 :
                          !sclk_rise ? bit_cnt :
                          char_end ? '0 : bit_cnt + 5'h01;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt <= '0;
        end else begin
            bit_cnt <= next_bit_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Event sources
    assign ev_set[BIT_TX_LEVEL] = fifo.tx_count < fifo.tx_thresh;
    assign ev_set[BIT_TX_EMPTY] = fifo.tx_count == '0;
    assign ev_set[BIT_RX_LEVEL] = fifo.rx_count > fifo.rx_thresh;
    assign ev_set[BIT_RX_FULL] =
        fifo.rx_count == CNT_W'(FIFO_DEPTH);
    assign ev_set[BIT_SSA] = |ss_asrt;
    assign ev_set[BIT_SSD] = |ss_deas;
    assign ev_set[BIT_RSV_LO] = 1'b0;
    assign ev_set[BIT_RSV_HI] = 1'b0;
    assign ev_set[BIT_FAULT] =
        (ctrl_master & ctrl_mm & ~&ss_s)
        | strb.collision;
    assign ev_set[BIT_ABORT] =
        ~ctrl_master & ss_deas[0] & (bit_cnt != '0);
    assign ev_set[BIT_RSV_MID] = 1'b0;
    assign ev_set[BIT_M_DONE] = ctrl_master & strb.master_done;
    assign ev_set[BIT_TX_OVR] = strb.tx_write_full;
    assign ev_set[BIT_TX_UND] =
        ~ctrl_master & strb.tx_read_empty;
    assign ev_set[BIT_RX_OVR] =
        ~ctrl_master & strb.rx_write_full;
    assign ev_set[BIT_RX_UND] = strb.rx_read_empty;

    ////////////////////////////////////////////////////////////////////
    // APB decode
    assign sel_ev = paddr == OFS_EVENT_FLAGS;
    assign sel_en = paddr == OFS_EVENT_ENABLES;
    assign sel_wk = paddr == OFS_WAKE_FLAGS;
    assign sel_wen = paddr == OFS_WAKE_ENABLES;
    assign sel_ctrl = paddr == OFS_CTRL;
    assign sel_stat = paddr == OFS_STATUS;
    assign addr_hit = sel_ev | sel_en | sel_wk | sel_wen | sel_ctrl
                      | sel_stat;
    assign acc_first = psel & penable & ~pready;
    assign wr_fire = psel & penable & pready & pwrite & addr_hit;

    // Write-one-clear masks
    assign ev_clr = (wr_fire & sel_ev) ?
                    pwdata[FLAG_W-1:0] & EVENT_USED : '0;
    assign wk_clr = (wr_fire & sel_wk) ?
                    pwdata[WAKE_W-1:0] & WAKE_USED : '0;

    // Read selection
    assign stat16 = {3'h0, bit_cnt, 8'h00} | 16'(ss_s);
    assign rd_data =
        sel_ev ? pad16(event_q) :
        sel_en ? pad16(event_en) :
        sel_wk ? pad16({12'h000, wake_q}) :
        sel_wen ? pad16({12'h000, wake_en}) :
        sel_ctrl ? pad16({7'h00, ctrl_len, 2'h0, ctrl_mm, ctrl_master}) :
        sel_stat ? pad16(stat16) : 32'h00000000;

    ////////////////////////////////////////////////////////////////////
    // Flag banks
    spiefw_flags #(
        .W(FLAG_W),
        .RST_VAL(EVENT_RST)
    ) u_event (
        .mclk(mclk),
        .rst_n(rst_n),
        .set(ev_set),
        .clr(ev_clr),
        .q(event_q)
    );

    spiefw_flags #(
        .W(WAKE_W),
        .RST_VAL(WAKE_RST)
    ) u_wake (
        .mclk(mclk),
        .rst_n(rst_n),
        .set(ev_set[WAKE_W-1:0]),
        .clr(wk_clr),
        .q(wake_q)
    );

    ////////////////////////////////////////////////////////////////////
    // Enable and control registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            event_en <= ENABLE_RST;
            wake_en <= WAKE_RST;
            ctrl_master <= 1'b0;
            ctrl_mm <= 1'b0;
            ctrl_len <= CHAR_BITS_RST;
        end else if (wr_fire) begin
            if (sel_en) begin
                event_en <= pwdata[FLAG_W-1:0] & EVENT_USED;
            end
            if (sel_wen) begin
                wake_en <= pwdata[WAKE_W-1:0] & WAKE_USED;
            end
            if (sel_ctrl) begin
                ctrl_master <= pwdata[CTRL_MASTER];
                ctrl_mm <= pwdata[CTRL_MM_EN];
                ctrl_len <= pwdata[CTRL_LEN_LSB +: LEN_W];
            end
        end
    end

    // APB answer one cycle into the access phase
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= acc_first;
            pslverr <= acc_first & ~addr_hit;
            if (acc_first) begin
                prdata <= pwrite ? 32'h00000000 : rd_data;
            end
        end
    end

    // Request outputs
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
            wake <= 1'b0;
        end else begin
            irq <= |(event_q & event_en);
            wake <= |(wake_q & wake_en);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    abort_set_a: assert property (
        !ctrl_master && ss_deas[0] && bit_cnt != '0
        |=> event_q[BIT_ABORT])
        else $error("abort flag not set");
    fault_set_a: assert property (
        (ctrl_master && ctrl_mm && !(&ss_s)) || strb.collision
        |=> event_q[BIT_FAULT])
        else $error("fault flag not set");
    ss_rel_a: assert property (
        $rose(ss_s[0]) |=> event_q[BIT_SSD])
        else $error("select release flag not set");
    ss_asrt_a: assert property (
        $fell(ss_s[0]) |=> event_q[BIT_SSA])
        else $error("select assert flag not set");
    rx_full_a: assert property (
        fifo.rx_count == CNT_W'(FIFO_DEPTH) |=> event_q[BIT_RX_FULL])
        else $error("rx full flag not set");
    rx_level_a: assert property (
        fifo.rx_count > fifo.rx_thresh |=> event_q[BIT_RX_LEVEL])
        else $error("rx level flag not set");
    tx_empty_a: assert property (
        fifo.tx_count == '0 |=> event_q[BIT_TX_EMPTY] && wake_q[BIT_TX_EMPTY])
        else $error("tx empty flag not set");
    tx_level_a: assert property (
        fifo.tx_count < fifo.tx_thresh |=> event_q[BIT_TX_LEVEL])
        else $error("tx level flag not set");
    flag_sticky_a: assert property (
        1'b1 |=> (($past(event_q) & ~$past(ev_clr) & ~event_q) == '0))
        else $error("event flag lost without clear");
    en_write_a: assert property (
        wr_fire && sel_en
        |=> event_en == ($past(pwdata[FLAG_W-1:0]) & EVENT_USED))
        else $error("enable write not stored");
    wake_sticky_a: assert property (
        1'b1 |=> ((($past(wake_q) & ~$past(wk_clr)) | $past(ev_set[3:0]))
                  == wake_q))
        else $error("wake flag wrong");
    wake_en_a: assert property (
        wr_fire && sel_wen
        |=> wake_en == ($past(pwdata[WAKE_W-1:0]) & WAKE_USED))
        else $error("wake enable write not stored");
    rx_und_a: assert property (
        strb.rx_read_empty |=> event_q[BIT_RX_UND])
        else $error("rx underrun flag not set");
    ovr_master_a: assert property (
        ctrl_master && !event_q[BIT_RX_OVR] |=> !event_q[BIT_RX_OVR])
        else $error("rx overrun set as master");
    und_master_a: assert property (
        ctrl_master && !event_q[BIT_TX_UND] |=> !event_q[BIT_TX_UND])
        else $error("tx underrun set as master");
    m_done_a: assert property (
        ctrl_master && strb.master_done |=> event_q[BIT_M_DONE])
        else $error("master done flag not set");
    irq_map_a: assert property (
        1'b1 |=> irq == |($past(event_q) & $past(event_en)))
        else $error("irq does not follow flags");
    wake_map_a: assert property (
        1'b1 |=> wake == |($past(wake_q) & $past(wake_en)))
        else $error("wake does not follow flags");

    irq_seen_c: cover property ($rose(irq));
    abort_seen_c: cover property ($rose(event_q[BIT_ABORT]));
    wake_seen_c: cover property ($rose(wake));
    clear_seen_c: cover property (wr_fire && sel_ev && ev_clr != '0);
endmodule : spiefw_top

`default_nettype wire

/* File: test/spiefw_peer.sv */
// Far-side model: an outside party driving the select and clock pins.
// Assumes the bench calls frame; pins stand idle between frames.
`default_nettype none

module spiefw_peer (
    output logic sclk,
    output logic [3:0] ss_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // Pins idle: clock still low, selects released high
    initial begin
        sclk = 1'b0;
        ss_n = 4'hF;
    end

    //////////////////////////////////////////////////////////////////////
    // Selects line n, gives nbits clocks of 160 ns, then releases it
    task automatic frame(input int n, input int nbits);
        ss_n[n] = 1'b0;
        #80;
        repeat (nbits) begin
            sclk = 1'b1;
            #80;
            sclk = 1'b0;
            #80;
        end
        ss_n[n] = 1'b1;
        #160;
    endtask : frame
endmodule : spiefw_peer

`default_nettype wire

/* File: test/tb.sv */
// Bench for the event flag, enable and wakeup registers over APB.
// Assumes spiefw_pkg, the design and spiefw_peer are compiled first.
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import spiefw_pkg::*;

    logic mclk;
    logic rst_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic apb_err;
    logic sclk;
    logic [3:0] ss_n;
    spiefw_fifo_t fifo;
    spiefw_strb_t strb;
    logic irq;
    logic wake;
    int n_errors = 0;
    int samples_checked = 0;

    spiefw_top #(.NUM_SS(4), .FIFO_DEPTH(32)) dut (
        .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sclk_in(sclk),
        .ss_n_in(ss_n), .fifo(fifo), .strb(strb), .irq(irq), .wake(wake)
    );

    spiefw_peer peer (.sclk(sclk), .ss_n(ss_n));

    // 50 MHz clock
    always #10 mclk = ~mclk;

    //////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    // One APB transfer: setup, then access held until pready
    task automatic apb(input logic wr, input logic [APB_AW-1:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int i;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge mclk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        if (i >= 50) begin
            n_errors++;
            $display("[FAIL] %0t no pready", $time);
            print_verdict();
        end else begin
            q = prdata;
            apb_err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    task automatic wr(input logic [APB_AW-1:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask : wr

    task automatic expect_reg(input logic [APB_AW-1:0] a,
                              input logic [31:0] exp);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        check(q, exp);
    endtask : expect_reg

    // FIFO levels with receive threshold 4 and transmit threshold 2
    function automatic spiefw_fifo_t lv(input logic [5:0] rx,
                                        input logic [5:0] tx);
        return '{rx_count: rx, tx_count: tx, rx_thresh: 6'h04,
                 tx_thresh: 6'h02};
    endfunction : lv

    //////////////////////////////////////////////////////////////////////
    // Reset values, write-one-clear and an unmapped address
    task automatic test_reset();
        logic [31:0] q;
        expect_reg(OFS_EVENT_FLAGS, 32'h0000_0002);
        expect_reg(OFS_EVENT_ENABLES, 32'h0);
        expect_reg(OFS_WAKE_FLAGS, 32'h0);
        expect_reg(OFS_WAKE_ENABLES, 32'h0);
        wr(OFS_EVENT_FLAGS, 32'h0000_0002);
        expect_reg(OFS_EVENT_FLAGS, 32'h0);
        apb(1'b0, 8'h10, 32'h0, q);
        check({31'h0, apb_err}, 32'h1);
    endtask : test_reset

    // Enable registers keep only their defined bits
    task automatic test_enables();
        wr(OFS_EVENT_ENABLES, 32'hFFFF_FFFF);
        expect_reg(OFS_EVENT_ENABLES, 32'h0000_FB3F);
        wr(OFS_WAKE_ENABLES, 32'hFFFF_FFFF);
        expect_reg(OFS_WAKE_ENABLES, 32'h0000_000F);
        wr(OFS_EVENT_ENABLES, 32'h0);
        wr(OFS_WAKE_ENABLES, 32'h0);
    endtask : test_enables

    // Each strobe in slave mode, three of them in master mode, refused ones included
    task automatic test_strobes();
        logic [31:0] ex;
        logic [5:0] s [9] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h01, 6'h02,
                              6'h02, 6'h10, 6'h08};
        logic [15:0] e [9] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000,
                               16'h0100, 16'h0000, 16'h0800, 16'h0000,
                               16'h0000};
        for (int k = 0; k < 9; k++) begin
            wr(OFS_CTRL, (k < 6) ? 32'h80 : 32'h81);
            strb <= s[k];
            @(posedge mclk);
            strb <= '0;
            ex = {16'h0, e[k]};
            expect_reg(OFS_EVENT_FLAGS, ex);
            wr(OFS_EVENT_FLAGS, 32'h0000_FFFF);
        end
        wr(OFS_CTRL, 32'h80);
    endtask : test_strobes

    // Masked then enabled underrun; flag holds until cleared
    task automatic test_irq();
        strb <= 6'h20;
        @(posedge mclk);
        strb <= '0;
        repeat (3) @(posedge mclk);
        check({31'h0, irq}, 32'h0);
        wr(OFS_EVENT_ENABLES, 32'h0000_8000);
        repeat (20) @(posedge mclk);
        check({31'h0, irq}, 32'h1);
        expect_reg(OFS_EVENT_FLAGS, 32'h0000_8000);
        wr(OFS_EVENT_FLAGS, 32'h0000_8000);
        repeat (2) @(posedge mclk);
        check({31'h0, irq}, 32'h0);
        wr(OFS_EVENT_ENABLES, 32'h0);
    endtask : test_irq

    // FIFO levels at the boundaries, then all four conditions and wake
    task automatic test_levels();
        fifo <= lv(6'h04, 6'h02);
        repeat (2) @(posedge mclk);
        expect_reg(OFS_EVENT_FLAGS, 32'h0);
        fifo <= lv(6'h20, 6'h00);
        repeat (2) @(posedge mclk);
        expect_reg(OFS_EVENT_FLAGS, 32'h0000_000F);
        expect_reg(OFS_WAKE_FLAGS, 32'h0000_000F);
        check({31'h0, wake}, 32'h0);
        wr(OFS_WAKE_ENABLES, 32'h0000_0008);
        repeat (2) @(posedge mclk);
        check({31'h0, wake}, 32'h1);
        fifo <= lv(6'h00, 6'h05);
        wr(OFS_WAKE_FLAGS, 32'h0000_000F);
        wr(OFS_EVENT_FLAGS, 32'h0000_000F);
        expect_reg(OFS_WAKE_FLAGS, 32'h0);
        check({31'h0, wake}, 32'h0);
        wr(OFS_WAKE_ENABLES, 32'h0);
    endtask : test_levels

    // Short and whole characters as slave, foreign select as master
    task automatic test_select();
        peer.frame(0, 3);
        repeat (8) @(posedge mclk);
        expect_reg(OFS_EVENT_FLAGS, 32'h0000_0230);
        wr(OFS_EVENT_FLAGS, 32'h0000_FFFF);
        peer.frame(0, 8);
        repeat (8) @(posedge mclk);
        expect_reg(OFS_EVENT_FLAGS, 32'h0000_0030);
        wr(OFS_EVENT_FLAGS, 32'h0000_FFFF);
        wr(OFS_CTRL, 32'h83);
        peer.frame(2, 2);
        repeat (8) @(posedge mclk);
        expect_reg(OFS_EVENT_FLAGS, 32'h0000_0130);
        wr(OFS_CTRL, 32'h80);
        wr(OFS_EVENT_FLAGS, 32'h0000_FFFF);
    endtask : test_select

    //////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        mclk = 1'b0;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        fifo = lv(6'h00, 6'h05);
        strb = '0;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        test_reset();
        test_enables();
        test_strobes();
        test_irq();
        test_levels();
        test_select();
        print_verdict();
    end
endmodule : tb

`default_nettype wire
